// ### omx_regs.sv
`default_nettype none

module omx_regs (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [omx_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic left_phone_mix_on,
  output logic right_phone_mix_on,
  output logic left_spk_mix_on,
  output logic right_spk_mix_on,
  output logic left_phone_amp_source,
  output logic right_phone_amp_source,
  output logic left_spk_amp_source,
  output omx_pkg::omx_sources_type left_phone_mix_sources,
  output omx_pkg::omx_sources_type right_phone_mix_sources,
  output omx_pkg::omx_sources_type left_spk_mix_sources,
  output omx_pkg::omx_level_type left_phone_mix_levels,
  output omx_pkg::omx_level_type right_phone_mix_levels
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Word-aligned slave: address is a word index, one register per word
  logic [6:0] idx;
  logic ack_r;
  logic wr_lo;
  logic wr_hi;
  assign idx = avs_address[6:0];
  assign wr_lo = avs_write && avs_byteenable[0] && ack_r;
  assign wr_hi = avs_write && avs_byteenable[1] && ack_r;

  // One wait state per access, so every access ends with waitrequest low
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  function automatic logic [8:0] merge(input logic [8:0] old, input logic [31:0] wd,
                                       input logic lo, input logic hi,
                                       input logic [8:0] mask);
    logic [8:0] v;
    v = old;
    if (lo) begin
      v[7:0] = wd[7:0];
    end
    if (hi) begin
      v[8] = wd[8];
    end
    return v & mask;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [8:0] enables_r;
  logic [8:0] lhp_route_r;
  logic [8:0] rhp_route_r;
  logic [8:0] lhp_level_r;
  logic [8:0] rhp_level_r;
  logic [8:0] lspk_route_r;
  logic hit;
  // Upper half of the index space is unmapped; without this a write there aliases low
  assign hit = (wr_lo || wr_hi) && !avs_address[7];

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      enables_r <= omx_pkg::RST_ENABLES;
    end else if (hit && idx == omx_pkg::IDX_ENABLES) begin
      enables_r <= merge(enables_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_ENABLES);
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lhp_route_r <= omx_pkg::RST_ROUTE;
    end else if (hit && idx == omx_pkg::IDX_LHP_ROUTE) begin
      lhp_route_r <= merge(lhp_route_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_ROUTE);
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rhp_route_r <= omx_pkg::RST_ROUTE;
    end else if (hit && idx == omx_pkg::IDX_RHP_ROUTE) begin
      rhp_route_r <= merge(rhp_route_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_ROUTE);
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lspk_route_r <= omx_pkg::RST_ROUTE;
    end else if (hit && idx == omx_pkg::IDX_LSPK_ROUTE) begin
      lspk_route_r <= merge(lspk_route_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_ROUTE);
    end
  end

  // Headphone mixers start muted with aux gain at code 7
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lhp_level_r <= omx_pkg::RST_LEVEL;
    end else if (hit && idx == omx_pkg::IDX_LHP_LEVEL) begin
      lhp_level_r <= merge(lhp_level_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_LEVEL);
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rhp_level_r <= omx_pkg::RST_LEVEL;
    end else if (hit && idx == omx_pkg::IDX_RHP_LEVEL) begin
      rhp_level_r <= merge(rhp_level_r, avs_writedata, wr_lo, wr_hi, omx_pkg::MASK_LEVEL);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back

  logic [8:0] rd_nxt;

  always_comb begin
    unique case (idx)
      omx_pkg::IDX_ENABLES: rd_nxt = enables_r;
      omx_pkg::IDX_LHP_ROUTE: rd_nxt = lhp_route_r;
      omx_pkg::IDX_RHP_ROUTE: rd_nxt = rhp_route_r;
      omx_pkg::IDX_LHP_LEVEL: rd_nxt = lhp_level_r;
      omx_pkg::IDX_RHP_LEVEL: rd_nxt = rhp_level_r;
      omx_pkg::IDX_LSPK_ROUTE: rd_nxt = lspk_route_r;
      default: rd_nxt = 9'h000;
    endcase
  end

  // Unmapped or high addresses read zero and ignore writes
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= (avs_address[7] == 1'b0) ? {23'h000000, rd_nxt} : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control lines, straight from the registers

  function automatic omx_pkg::omx_sources_type srcs(input logic [8:0] r);
    return omx_pkg::omx_sources_type'(r[5:0]);
  endfunction : srcs

  function automatic omx_pkg::omx_level_type lvl(input logic [8:0] r);
    omx_pkg::omx_level_type l;
    l.silence = r[omx_pkg::POS_MUTE];
    l.left_in_atten = r[omx_pkg::POS_ATT_L];
    l.right_in_atten = r[omx_pkg::POS_ATT_R];
    l.aux_left_gain = r[omx_pkg::POS_AUXL_LSB +: omx_pkg::GAIN_W];
    l.aux_right_gain = r[omx_pkg::POS_AUXR_LSB +: omx_pkg::GAIN_W];
    return l;
  endfunction : lvl

  assign left_phone_mix_on = enables_r[omx_pkg::POS_EN_LHP];
  assign right_phone_mix_on = enables_r[omx_pkg::POS_EN_RHP];
  assign left_spk_mix_on = enables_r[omx_pkg::POS_EN_LSPK];
  assign right_spk_mix_on = enables_r[omx_pkg::POS_EN_RSPK];
  assign left_phone_amp_source = lhp_route_r[omx_pkg::POS_AMP_SRC];
  assign right_phone_amp_source = rhp_route_r[omx_pkg::POS_AMP_SRC];
  assign left_spk_amp_source = lspk_route_r[omx_pkg::POS_AMP_SRC];
  assign left_phone_mix_sources = srcs(lhp_route_r);
  assign right_phone_mix_sources = srcs(rhp_route_r);
  assign left_spk_mix_sources = srcs(lspk_route_r);
  assign left_phone_mix_levels = lvl(lhp_level_r);
  assign right_phone_mix_levels = lvl(rhp_level_r);

endmodule : omx_regs

`default_nettype wire

// ### omx_pkg.sv
// Behaviour
// - The enable register holds four independent mixer enables in bits 3..0, all reset clear.
// - Bit 7 of the left headphone routing register picks the left headphone amp source, reset 0.
// - Bit 7 of the right headphone routing register picks the right headphone amp source, reset 0.
// - Bit 7 of the left speaker routing register picks the left speaker amp source, reset 0.
// - The left headphone routing register has six source-connect bits 5..0, reset disconnected.
// - The right headphone routing register has the same six source-connect bits, reset clear.
// - The left speaker routing register has the same six source-connect bits, reset clear.
// - Bit 8 of the left headphone level register mutes that mixer and resets set.
// - Bit 8 of the right headphone level register mutes that mixer and resets set.
// - Bits 7 and 6 of the left headphone level register pick 0 or 6 dB cut, reset 0.
// - Bits 7 and 6 of the right headphone level register pick 0 or 6 dB cut, reset 0.
// - Each aux gain field is three bits, -15 dB at 0 in 3 dB steps, resetting to code 7.
// - Level register bits 5:3 hold aux left gain and bits 2:0 aux right gain.
`default_nettype none

package omx_pkg;

  localparam int ADDR_W = 8;
  localparam int REG_W = 9;

  // Word index; byte address is four times this
  localparam logic [6:0] IDX_ENABLES = 7'h63;
  localparam logic [6:0] IDX_LHP_ROUTE = 7'h64;
  localparam logic [6:0] IDX_RHP_ROUTE = 7'h65;
  localparam logic [6:0] IDX_LHP_LEVEL = 7'h66;
  localparam logic [6:0] IDX_RHP_LEVEL = 7'h67;
  localparam logic [6:0] IDX_LSPK_ROUTE = 7'h69;

  // Defined-bit masks
  localparam logic [8:0] MASK_ENABLES = 9'h00F;
  localparam logic [8:0] MASK_ROUTE = 9'h0BF;
  localparam logic [8:0] MASK_LEVEL = 9'h1FF;

  // Reset values
  localparam logic [8:0] RST_ENABLES = 9'h000;
  localparam logic [8:0] RST_ROUTE = 9'h000;
  localparam logic [8:0] RST_LEVEL = 9'h13F;

  // Field positions
  localparam int POS_AMP_SRC = 7;
  localparam int POS_MUTE = 8;
  localparam int POS_ATT_L = 7;
  localparam int POS_ATT_R = 6;
  localparam int POS_AUXL_LSB = 3;
  localparam int POS_AUXR_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int POS_EN_LHP = 3;
  localparam int POS_EN_RHP = 2;
  localparam int POS_EN_LSPK = 1;
  localparam int POS_EN_RSPK = 0;

  typedef struct packed {
    logic left_converter_out;
    logic right_converter_out;
    logic left_input_mix;
    logic right_input_mix;
    logic aux_left_input;
    logic aux_right_input;
  } omx_sources_type;

  typedef struct packed {
    logic silence;
    logic left_in_atten;
    logic right_in_atten;
    logic [2:0] aux_left_gain;
    logic [2:0] aux_right_gain;
  } omx_level_type;

endpackage : omx_pkg

`default_nettype wire

// ### omx_regs_assertions.sv
`default_nettype none
module omx_regs_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [omx_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic right_spk_mix_on,
  input wire logic left_spk_amp_source,
  input wire omx_pkg::omx_level_type left_phone_mix_levels
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wr_ok;
  logic lvl_wr;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign lvl_wr = wr_ok && avs_address == 8'h66;
  property p_one_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait too long");
  property p_idle; !avs_read && !avs_write |-> !avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_en; wr_ok && avs_address == 8'h63 && avs_byteenable[0]
    |=> right_spk_mix_on == $past(avs_writedata[0]); endproperty
  a_en: assert property (p_en) else $error("enable wrong");
  property p_src; wr_ok && avs_address == 8'h69 && avs_byteenable[0]
    |=> left_spk_amp_source == $past(avs_writedata[7]); endproperty
  a_src: assert property (p_src) else $error("amp source wrong");
  property p_mute; lvl_wr && avs_byteenable[1]
    |=> left_phone_mix_levels.silence == $past(avs_writedata[8]); endproperty
  a_mute: assert property (p_mute) else $error("mute wrong");
  property p_keep; lvl_wr && !avs_byteenable[1] |=> $stable(left_phone_mix_levels.silence); endproperty
  a_keep: assert property (p_keep) else $error("mute changed");
  property p_gain; lvl_wr && avs_byteenable[0]
    |=> left_phone_mix_levels.aux_left_gain == $past(avs_writedata[5:3]); endproperty
  a_gain: assert property (p_gain) else $error("gain wrong");
  property p_hole; avs_read && !avs_waitrequest && avs_address == 8'h68 |-> avs_readdata == 32'h0; endproperty
  a_hole: assert property (p_hole) else $error("hole not zero");
  property p_alias; wr_ok && avs_address[7] |=> $stable(right_spk_mix_on); endproperty
  a_alias: assert property (p_alias) else $error("high address write landed");
endmodule : omx_regs_checker
bind omx_regs omx_regs_checker i_chk (.*);
`default_nettype wire

// ### omx_mixer_model.sv
`default_nettype none
module omx_mixer_model (
  input wire logic left_phone_mix_on,
  input wire logic right_phone_mix_on,
  input wire logic left_spk_mix_on,
  input wire logic right_spk_mix_on,
  input wire logic left_phone_amp_source,
  input wire logic right_phone_amp_source,
  input wire logic left_spk_amp_source,
  input wire omx_pkg::omx_sources_type left_phone_mix_sources,
  input wire omx_pkg::omx_sources_type right_phone_mix_sources,
  input wire omx_pkg::omx_sources_type left_spk_mix_sources,
  input wire omx_pkg::omx_level_type left_phone_mix_levels,
  input wire omx_pkg::omx_level_type right_phone_mix_levels,
  output logic [8:0] word [0:6]
);
  // Mixers see only the control lines; regrouped per word for comparison
  assign word[0] = {5'h00, left_phone_mix_on, right_phone_mix_on,
    left_spk_mix_on, right_spk_mix_on};
  assign word[1] = {1'b0, left_phone_amp_source, 1'b0, left_phone_mix_sources};
  assign word[2] = {1'b0, right_phone_amp_source, 1'b0, right_phone_mix_sources};
  assign word[3] = left_phone_mix_levels;
  assign word[4] = right_phone_mix_levels;
  assign word[5] = 9'h000;
  assign word[6] = {1'b0, left_spk_amp_source, 1'b0, left_spk_mix_sources};
endmodule : omx_mixer_model
`default_nettype wire

// ### tb_omx_regs.sv
`default_nettype none
module tb_omx_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic left_phone_mix_on, right_phone_mix_on, left_spk_mix_on, right_spk_mix_on;
  logic left_phone_amp_source, right_phone_amp_source, left_spk_amp_source;
  omx_pkg::omx_sources_type left_phone_mix_sources, right_phone_mix_sources, left_spk_mix_sources;
  omx_pkg::omx_level_type left_phone_mix_levels, right_phone_mix_levels;
  logic [8:0] word [0:6];
  int err_count = 0;
  int checked = 0;
  logic [7:0] adr [6] = '{8'h63, 8'h64, 8'h65, 8'h66, 8'h67, 8'h69};
  logic [8:0] rst [6] = '{9'h000, 9'h000, 9'h000, 9'h13F, 9'h13F, 9'h000};
  logic [8:0] msk [6] = '{9'h00F, 9'h0BF, 9'h0BF, 9'h1FF, 9'h1FF, 9'h0BF};
  omx_regs i_dut (.*);
  omx_mixer_model i_mdl (.*);
  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH reg %h exp %h seen %h", avs_address, exp, seen);
    end
  endtask : chk
  // Request held until the edge that samples waitrequest low; data taken there
  task automatic xfer(input logic w, input logic [7:0] a, input logic [8:0] d,
                      input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {23'h000000, d};
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : xfer
  task automatic check_reset_values;
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, adr[i], 9'h000, 4'hF);
      chk(q, 32'(rst[i]));
      chk(32'(word[adr[i] - 8'h63]), 32'(rst[i]));
    end
  endtask : check_reset_values
  task automatic conclude;
    if (err_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  ////////////////////////////////////////
  initial begin
    #50us;
    err_count++;
    conclude();
  end
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check_reset_values();
    for (int v = 0; v < 2; v++) begin
      for (int i = 0; i < 6; i++) begin
        xfer(1'b1, adr[i], v ? 9'h000 : 9'h1FF, 4'hF);
        xfer(1'b0, adr[i], 9'h000, 4'hF);
        chk(q, v ? 32'h0 : 32'(msk[i]));
        chk(32'(word[adr[i] - 8'h63]), v ? 32'h0 : 32'(msk[i]));
      end
    end
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, 8'h66, 9'(c * 9) | 9'h080, 4'hF);
      xfer(1'b0, 8'h66, 9'h000, 4'hF);
      chk(32'(left_phone_mix_levels), 32'(c * 9) | 32'h80);
    end
    xfer(1'b1, 8'h66, 9'h1FF, 4'h1);
    xfer(1'b0, 8'h66, 9'h000, 4'hF);
    chk(q, 32'h0FF);
    xfer(1'b1, 8'h68, 9'h1FF, 4'hF);
    xfer(1'b0, 8'h68, 9'h000, 4'hF);
    chk(q, 32'h0);
    xfer(1'b0, 8'hE3, 9'h000, 4'hF);
    chk(q, 32'h0);
    xfer(1'b1, 8'hE3, 9'h1FF, 4'hF);
    xfer(1'b0, 8'h63, 9'h000, 4'hF);
    chk(q, 32'h0);
    chk(32'(word[0]), 32'h0);
    // Second reset with non-default contents in place
    xfer(1'b1, 8'h63, 9'h00F, 4'hF);
    xfer(1'b1, 8'h67, 9'h000, 4'hF);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check_reset_values();
    conclude();
  end
endmodule : tb_omx_regs
`default_nettype wire
